// *** common/ovs_consts.svh ***
// constants for the output volume soft mute and ultrasonic block
// assumes byte addressing on a 32-bit AXI4-Lite register bus
`ifndef OVS_CONSTS_SVH
`define OVS_CONSTS_SVH

`define OVS_ADDR_W 16
`define OVS_OFF_REC_FILTER 16'h0410
`define OVS_OFF_SOFT_MUTE 16'h0614
`define OVS_OFF_MUTE_CTRL 16'h0600
`define OVS_OFF_VOL_PLAY 16'h0620
`define OVS_OFF_VOL_TX 16'h0624
`define OVS_OFF_GAIN_STAT 16'h0630

`define OVS_BIT_ULTRA 15
`define OVS_BIT_UNMUTE_RAMP 1
`define OVS_BIT_RAMP_RATE 0

`define OVS_RST_MUTE 4'h F
`define OVS_RST_VOL 8'h C0
`define OVS_MUTED_CODE 8'h 00
`define OVS_MAX_CODE 8'h E0

// fs ticks per volume step: fast fs/2, slow fs/32
`define OVS_FAST_DIV 5'h 01
`define OVS_SLOW_DIV 5'h 1F
`define OVS_QUARTERS 2'h 3

`define OVS_RESP_OKAY 2'b00
`define OVS_RESP_SLVERR 2'b10

`endif

// *** common/ovs_pkg.sv ***
// types for the output volume soft mute and ultrasonic block
// assumes the constants header is included by the design file
package ovs_pkg;

  // applied gain codes: [0] playback left, [1] playback right,
  // [2] second port tx left, [3] second port tx right
  typedef struct packed {
    logic [3:0][7:0] code;
  } ovs_gains_t;

  // bypass and availability flags of the record path
  typedef struct packed {
    logic filter_bypass;
    logic volume_bypass;
    logic rec_drc_avail;
    logic play_drc_avail;
  } ovs_rec_flags_t;

endpackage

// *** src/ovs_softmute.sv ***
// output volume stage with soft mute / soft un-mute ramping and the
// ultrasonic four-times-rate record output mode, with AXI4-Lite registers
// assumes FS_TICK is a one-cycle pulse per sample from logic on CLK_SYS
//
// What this block does
// - volume codes step 0.375 dB each and codes E0h to FFh all give +12 dB.
// - asserting a mute ramps that channel's gain down gradually.
// - unmute ramp select 0 restores the volume at once, 1 ramps up to it.
// - the upward ramp uses the same rate selection as the mute ramp.
// - ramp rate select 0 steps at fs/2 and 1 steps at fs/32.
// - after reset every channel is muted until software clears the mute.
// - ramp duration grows with the gain distance, at a fixed step speed.
// - ultrasonic mode makes the record output run at four times fs.
// - ultrasonic mode bypasses record filtering and record volume.
// - ultrasonic mode removes dynamic range control from record paths only.
// - bit 15 of the record filter register enables ultrasonic mode, reset 0.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ovs_consts.svh"

module ovs_softmute #(
  parameter int PERIOD_W = 16
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // sample rate enable
  input wire logic FS_TICK,
  // axi4-lite write
  input wire logic [`OVS_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [`OVS_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // datapath controls
  output ovs_pkg::ovs_gains_t GAIN,
  output ovs_pkg::ovs_rec_flags_t REC_FLAGS,
  output logic REC_SAMPLE_TICK
);

  // registers
  logic ultrasonic_output_enable_reg;
  logic unmute_ramp_select_reg;
  logic volume_ramp_rate_select_reg;
  logic [3:0] mute_reg;
  logic [3:0][7:0] volume_reg;
  logic [3:0][7:0] gain_reg;

  // bus state
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_full_reg, w_full_reg;
  logic [`OVS_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;

  // ramp and rate state
  logic [4:0] fs_div_reg;
  logic ramp_tick_reg;
  logic [PERIOD_W-1:0] cyc_cnt_reg, period_reg, sub_cnt_reg;
  logic [1:0] sub_idx_reg;
  logic rec_tick_reg;
  ovs_pkg::ovs_rec_flags_t flags_reg;

  // effective target code: the +12 dB ceiling
  function automatic logic [7:0] cap_code(input logic [7:0] c);
    cap_code = (c >= `OVS_MAX_CODE) ? `OVS_MAX_CODE : c;
  endfunction

  // one code toward the target
  function automatic logic [7:0] step_to(input logic [7:0] g,
                                         input logic [7:0] t);
    if (g < t) begin
      step_to = g + 8'h01;
    end else if (g > t) begin
      step_to = g - 8'h01;
    end else begin
      step_to = g;
    end
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // address decode
  wire logic wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
  wire logic wr_rf = awaddr_reg == `OVS_OFF_REC_FILTER;
  wire logic wr_sm = awaddr_reg == `OVS_OFF_SOFT_MUTE;
  wire logic wr_mc = awaddr_reg == `OVS_OFF_MUTE_CTRL;
  wire logic wr_vp = awaddr_reg == `OVS_OFF_VOL_PLAY;
  wire logic wr_vt = awaddr_reg == `OVS_OFF_VOL_TX;
  wire logic wr_hit = wr_rf || wr_sm || wr_mc || wr_vp || wr_vt;
  wire logic [15:0] rf_word = {ultrasonic_output_enable_reg, 15'h0000};
  wire logic [15:0] sm_word = {14'h0000, unmute_ramp_select_reg,
                               volume_ramp_rate_select_reg};
  wire logic [15:0] mc_word = {12'h000, mute_reg};
  wire logic [15:0] vp_word = {volume_reg[1], volume_reg[0]};
  wire logic [15:0] vt_word = {volume_reg[3], volume_reg[2]};
  wire logic [15:0] rf_new = merge16(rf_word, wdata_reg, wstrb_reg);
  wire logic [15:0] sm_new = merge16(sm_word, wdata_reg, wstrb_reg);
  wire logic [15:0] mc_new = merge16(mc_word, wdata_reg, wstrb_reg);
  wire logic [15:0] vp_new = merge16(vp_word, wdata_reg, wstrb_reg);
  wire logic [15:0] vt_new = merge16(vt_word, wdata_reg, wstrb_reg);
  wire logic rd_take = S_AXI_ARVALID && arready_reg;
  wire logic rd_rf = S_AXI_ARADDR == `OVS_OFF_REC_FILTER;
  wire logic rd_sm = S_AXI_ARADDR == `OVS_OFF_SOFT_MUTE;
  wire logic rd_mc = S_AXI_ARADDR == `OVS_OFF_MUTE_CTRL;
  wire logic rd_vp = S_AXI_ARADDR == `OVS_OFF_VOL_PLAY;
  wire logic rd_vt = S_AXI_ARADDR == `OVS_OFF_VOL_TX;
  wire logic rd_gs = S_AXI_ARADDR == `OVS_OFF_GAIN_STAT;
  wire logic rd_hit = rd_rf || rd_sm || rd_mc || rd_vp || rd_vt || rd_gs;
  wire logic [31:0] rd_data =
    rd_rf ? {16'h0000, rf_word} :
    rd_sm ? {16'h0000, sm_word} :
    rd_mc ? {16'h0000, mc_word} :
    rd_vp ? {16'h0000, vp_word} :
    rd_vt ? {16'h0000, vt_word} :
    rd_gs ? gain_reg : 32'h0000_0000;

  // ramp step enable
  wire logic [4:0] div_end = volume_ramp_rate_select_reg ?
                             `OVS_SLOW_DIV : `OVS_FAST_DIV;
  wire logic div_wrap = FS_TICK && (fs_div_reg >= div_end);

  // write channel
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `OVS_RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && awready_reg) begin
        awaddr_reg <= S_AXI_AWADDR;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (S_AXI_WVALID && wready_reg) begin
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `OVS_RESP_OKAY : `OVS_RESP_SLVERR;
      end
      if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `OVS_RESP_OKAY;
    end else if (rd_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_hit ? `OVS_RESP_OKAY : `OVS_RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // control registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ultrasonic_output_enable_reg <= 1'b0;
      unmute_ramp_select_reg <= 1'b0;
      volume_ramp_rate_select_reg <= 1'b0;
      mute_reg <= `OVS_RST_MUTE;
      volume_reg <= {4{`OVS_RST_VOL}};
    end else if (wr_go) begin
      if (wr_rf) begin
        ultrasonic_output_enable_reg <= rf_new[`OVS_BIT_ULTRA];
      end
      if (wr_sm) begin
        unmute_ramp_select_reg <= sm_new[`OVS_BIT_UNMUTE_RAMP];
        volume_ramp_rate_select_reg <= sm_new[`OVS_BIT_RAMP_RATE];
      end
      if (wr_mc) begin
        mute_reg <= mc_new[3:0];
      end
      if (wr_vp) begin
        volume_reg[0] <= vp_new[7:0];
        volume_reg[1] <= vp_new[15:8];
      end
      if (wr_vt) begin
        volume_reg[2] <= vt_new[7:0];
        volume_reg[3] <= vt_new[15:8];
      end
    end
  end

  // fs divider for the ramp period
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      fs_div_reg <= 5'h00;
      ramp_tick_reg <= 1'b0;
    end else begin
      ramp_tick_reg <= div_wrap;
      if (div_wrap) begin
        fs_div_reg <= 5'h00;
      end else if (FS_TICK) begin
        fs_div_reg <= fs_div_reg + 5'h01;
      end
    end
  end

  // per-channel applied gain
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      gain_reg <= {4{`OVS_MUTED_CODE}};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (mute_reg[i]) begin
          if (ramp_tick_reg) begin
            gain_reg[i] <= step_to(gain_reg[i], `OVS_MUTED_CODE);
          end
        end else if (!unmute_ramp_select_reg) begin
          gain_reg[i] <= cap_code(volume_reg[i]);
        end else if (ramp_tick_reg) begin
          gain_reg[i] <= step_to(gain_reg[i],
                                 cap_code(volume_reg[i]));
        end
      end
    end
  end

  // ultrasonic record rate: split each fs period in four
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cyc_cnt_reg <= '0;
      period_reg <= '0;
      sub_cnt_reg <= '0;
      sub_idx_reg <= 2'h0;
      rec_tick_reg <= 1'b0;
    end else if (FS_TICK) begin
      period_reg <= cyc_cnt_reg + PERIOD_W'(1);
      cyc_cnt_reg <= '0;
      sub_cnt_reg <= '0;
      sub_idx_reg <= 2'h0;
      rec_tick_reg <= 1'b1;
    end else begin
      cyc_cnt_reg <= cyc_cnt_reg + PERIOD_W'(1);
      sub_cnt_reg <= sub_cnt_reg + PERIOD_W'(1);
      rec_tick_reg <= 1'b0;
      if (ultrasonic_output_enable_reg && sub_idx_reg < `OVS_QUARTERS &&
          sub_cnt_reg + PERIOD_W'(1) >= (period_reg >> 2)) begin
        rec_tick_reg <= 1'b1;
        sub_cnt_reg <= '0;
        sub_idx_reg <= sub_idx_reg + 2'h1;
      end
    end
  end

  // record path flags
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      flags_reg <= '{1'b0, 1'b0, 1'b1, 1'b1};
    end else begin
      flags_reg.filter_bypass <= ultrasonic_output_enable_reg;
      flags_reg.volume_bypass <= ultrasonic_output_enable_reg;
      flags_reg.rec_drc_avail <= !ultrasonic_output_enable_reg;
      flags_reg.play_drc_avail <= 1'b1;
    end
  end

  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY = wready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign GAIN.code = gain_reg;
  assign REC_FLAGS = flags_reg;
  assign REC_SAMPLE_TICK = rec_tick_reg;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  property p_gain_cap;
    gain_reg[0] <= `OVS_MAX_CODE && gain_reg[3] <= `OVS_MAX_CODE;
  endproperty
  a_gain_cap: assert property (p_gain_cap)
    else $error("applied gain above +12 dB code");

  property p_mute_step;
    mute_reg[0] && ramp_tick_reg && gain_reg[0] != 8'h00
      |=> gain_reg[0] == $past(gain_reg[0]) - 8'h01;
  endproperty
  a_mute_step: assert property (p_mute_step)
    else $error("muted gain did not step down by one code");

  property p_unmute_now;
    !mute_reg[1] && !unmute_ramp_select_reg
      |=> gain_reg[1] == cap_code($past(volume_reg[1]));
  endproperty
  a_unmute_now: assert property (p_unmute_now)
    else $error("immediate unmute did not restore volume");

  property p_step_only_on_tick;
    unmute_ramp_select_reg && $past(unmute_ramp_select_reg) &&
      $changed(gain_reg[2]) |-> $past(ramp_tick_reg);
  endproperty
  a_step_only_on_tick: assert property (p_step_only_on_tick)
    else $error("gain moved outside a ramp period");

  property p_fast_rate;
    !volume_ramp_rate_select_reg && FS_TICK && fs_div_reg == 5'h01
      |=> ramp_tick_reg;
  endproperty
  a_fast_rate: assert property (p_fast_rate)
    else $error("fast ramp did not fire every second sample");

  property p_reset_muted;
    $past(RESET) |-> mute_reg == 4'hF && gain_reg == 32'h0000_0000;
  endproperty
  a_reset_muted: assert property (p_reset_muted)
    else $error("channels not muted after reset");

  property p_one_code;
    unmute_ramp_select_reg && $past(unmute_ramp_select_reg) |->
      (gain_reg[3] - $past(gain_reg[3]) <= 8'h01 ||
       $past(gain_reg[3]) - gain_reg[3] <= 8'h01);
  endproperty
  a_one_code: assert property (p_one_code)
    else $error("ramp moved more than one code");

  property p_rec_tick;
    FS_TICK |=> rec_tick_reg;
  endproperty
  a_rec_tick: assert property (p_rec_tick)
    else $error("record tick missing on a sample");

  property p_bypass;
    ##1 flags_reg.volume_bypass == $past(ultrasonic_output_enable_reg) &&
      flags_reg.filter_bypass == $past(ultrasonic_output_enable_reg);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("record bypass does not follow ultrasonic mode");

  property p_drc;
    flags_reg.rec_drc_avail != flags_reg.filter_bypass &&
      flags_reg.play_drc_avail;
  endproperty
  a_drc: assert property (p_drc)
    else $error("dynamic range control availability wrong");

  property p_ultra_reset;
    $past(RESET) |-> !ultrasonic_output_enable_reg;
  endproperty
  a_ultra_reset: assert property (p_ultra_reset)
    else $error("ultrasonic mode not off after reset");

  c_ramp_down: cover property (mute_reg[0] && ramp_tick_reg ##1
                               gain_reg[0] == 8'h00);
  c_ramp_up: cover property (unmute_ramp_select_reg && !mute_reg[0] &&
                             ramp_tick_reg);
  c_ultra: cover property (ultrasonic_output_enable_reg && rec_tick_reg &&
                           !FS_TICK);

endmodule

// *** dv/ovs_host_model.sv ***
// host audio processor model: paces samples, counts record samples
// assumes the record tick and the sample pace share clk_sys
`timescale 1ns/1ps
module ovs_host_model #(
  parameter int FS_PERIOD = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // sample pacing and record samples
  output logic fs_tick,
  input wire logic rec_tick,
  output logic [15:0] rec_count
);
  int cnt;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt <= 0;
      fs_tick <= 1'b0;
      rec_count <= 16'h0000;
    end else begin
      cnt <= (cnt == FS_PERIOD - 1) ? 0 : cnt + 1;
      fs_tick <= (cnt == FS_PERIOD - 1);
      if (rec_tick) rec_count <= rec_count + 16'h0001;
    end
  end
endmodule

// *** dv/ovs_softmute_tb.sv ***
// self-checking bench for the soft mute volume stage over AXI4-Lite
// assumes the host model paces one sample every 8 clocks
`timescale 1ns/1ps
`include "ovs_consts.svh"
module ovs_softmute_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic fs_tick, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rec_tick;
  logic [15:0] awaddr, araddr, rec_count;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  ovs_pkg::ovs_gains_t gain;
  ovs_pkg::ovs_rec_flags_t flags;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [15:0] c0;

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  ovs_softmute #(.PERIOD_W(16)) uut (
    .CLK_SYS(clk_sys), .RESET(reset), .FS_TICK(fs_tick),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .GAIN(gain),
    .REC_FLAGS(flags), .REC_SAMPLE_TICK(rec_tick)
  );

  ovs_host_model #(.FS_PERIOD(8)) host (
    .clk_sys(clk_sys), .reset(reset), .fs_tick(fs_tick),
    .rec_tick(rec_tick), .rec_count(rec_count)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic timeout(input string nm);
    $display("FAIL %s expected answer seen none", nm);
    err_total++;
    print_verdict();
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // ready is a flop, so its level at the falling edge is what the
  // next rising edge samples
  task automatic wr(input logic [15:0] a, input logic [15:0] v,
                    input logic [1:0] er);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, v};
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100 && !tb; n++) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    if (!tb) timeout("write");
    chk("bresp", {30'h0, er}, {30'h0, r});
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, tb;
    tb = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100 && !tb; n++) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      tb = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
      if (tb) rready <= 1'b0;
    end
    if (!tb) timeout("read");
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic wait_chg(input int ch, output int t);
    logic [7:0] v;
    int n;
    v = gain.code[ch];
    for (n = 0; n < 600 && gain.code[ch] === v; n++) @(negedge clk_sys);
    if (n == 600) timeout("gain change");
    t = cyc;
  endtask

  // one ramp step: spacing in clocks and size of the step
  task automatic ramp(input int ch, input int gap, input int dir);
    int t0, t1;
    logic [7:0] v0;
    wait_chg(ch, t0);
    v0 = gain.code[ch];
    wait_chg(ch, t1);
    chk("ramp gap", 32'(gap), 32'(t1 - t0));
    chk("ramp step", 32'(8'(v0 + dir)), {24'h0, gain.code[ch]});
  endtask

  task automatic count_rec(input logic [15:0] e);
    c0 = rec_count;
    repeat (80) @(negedge clk_sys);
    chk("record samples", {16'h0, e}, {16'h0, rec_count - c0});
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'b0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk("gain reset", 32'h0000_0000, gain);
    chk("flags reset", 32'h0000_0003, {28'h0, flags});
    rd(`OVS_OFF_REC_FILTER, 32'h0000_0000, `OVS_RESP_OKAY);
    rd(`OVS_OFF_SOFT_MUTE, 32'h0000_0000, `OVS_RESP_OKAY);
    rd(`OVS_OFF_MUTE_CTRL, 32'h0000_000F, `OVS_RESP_OKAY);
    rd(16'h0700, 32'h0000_0000, `OVS_RESP_SLVERR);
    wr(16'h0700, 16'h1234, `OVS_RESP_SLVERR);
    $display("test reset done");
    wr(`OVS_OFF_MUTE_CTRL, 16'h0000, `OVS_RESP_OKAY);
    @(negedge clk_sys);
    chk("unmute at once", 32'hC0C0_C0C0, gain);
    rd(`OVS_OFF_GAIN_STAT, 32'hC0C0_C0C0, `OVS_RESP_OKAY);
    wr(`OVS_OFF_VOL_PLAY, 16'hFFBF, `OVS_RESP_OKAY);
    @(negedge clk_sys);
    chk("volume clamp", 32'hC0C0_E0BF, gain);
    $display("test immediate done");
    wr(`OVS_OFF_MUTE_CTRL, 16'h0001, `OVS_RESP_OKAY);
    ramp(0, 16, -1);
    chk("other held", 32'h0000_00E0, {24'h0, gain.code[1]});
    wr(`OVS_OFF_SOFT_MUTE, 16'h0001, `OVS_RESP_OKAY);
    wr(`OVS_OFF_MUTE_CTRL, 16'h0005, `OVS_RESP_OKAY);
    ramp(2, 256, -1);
    $display("test mute ramp done");
    wr(`OVS_OFF_SOFT_MUTE, 16'h0003, `OVS_RESP_OKAY);
    wr(`OVS_OFF_MUTE_CTRL, 16'h0000, `OVS_RESP_OKAY);
    ramp(2, 256, 1);
    chk("tx right held", 32'h0000_00C0, {24'h0, gain.code[3]});
    $display("test unmute ramp done");
    count_rec(16'd10);
    wr(`OVS_OFF_REC_FILTER, 16'h8000, `OVS_RESP_OKAY);
    rd(`OVS_OFF_REC_FILTER, 32'h0000_8000, `OVS_RESP_OKAY);
    chk("flags ultra", 32'h0000_000D, {28'h0, flags});
    repeat (40) @(negedge clk_sys);
    count_rec(16'd40);
    $display("test ultrasonic done");
    // byte lane 0 only: the right tx volume keeps its reset code
    @(posedge clk_sys);
    wstrb <= 4'h1;
    wr(`OVS_OFF_VOL_TX, 16'hFF10, `OVS_RESP_OKAY);
    @(posedge clk_sys);
    wstrb <= 4'hF;
    rd(`OVS_OFF_VOL_TX, 32'h0000_C010, `OVS_RESP_OKAY);
    $display("test byte strobe done");
    // reset in mid-run mutes again and clears ultrasonic mode
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk("gain re-reset", 32'h0000_0000, gain);
    chk("flags re-reset", 32'h0000_0003, {28'h0, flags});
    rd(`OVS_OFF_MUTE_CTRL, 32'h0000_000F, `OVS_RESP_OKAY);
    rd(`OVS_OFF_REC_FILTER, 32'h0000_0000, `OVS_RESP_OKAY);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
